// [rtl/adcc_ctrl.sv]
// Conversion control of a 12-bit successive approximation converter.
`timescale 1ns/1ps
// What this block does
// - Offset trim is 16 bits, top two zero.
// - Larger offset trim corrects more negative offset.
// - Offset trim sits near 0010 0000 0000 0000.
// - Offset bits binary weighted, top worth 5%.
// - Gain trim 16 bits, 14 data, top 2.5%.
// - Gain trim scales result within 0.975 to 1.025.
// - Start by pin pulse or control write.
// - Hold on start rising edge or write end.
// - Begin on next master fall after 10 ns setup.
// - Conversion 16.5 periods, 17.5 if setup missed.
// - Busy falls at end, result then readable.
// - Busy falling edge clears software start bit unless a start write ends then.
// - First start after power-up runs self-calibration.
// - Read with chip select drives the result.
// - Status bit 4 shows busy.
// - Track again on busy fall, 400 ns acquisition.
module adcc_ctrl #(
    parameter int unsigned CAL_FALLS = 64, // Master clock falls of a self-calibration.
    parameter logic [15:0] OFFSET_CAL = 16'h2000, // Offset trim left by calibration.
    parameter logic [15:0] GAIN_CAL = 16'h2000 // Gain trim left by calibration.
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic master_clock_in,
    input wire logic convert_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] addr,
    input wire logic [15:0] data_in,
    input wire logic cmp_high,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic busy,
    output logic hold,
    output logic [11:0] dac_code
);
    import adcc_pkg::*;

    // All state of the sequencer.
    typedef struct packed {
        logic [23:0] s1; // First synchroniser stage.
        logic [23:0] s2; // Second stage.
        logic [23:0] s3; // Third stage.
        logic [23:0] filt; // Pin levels accepted once stages two and three agree.
        adcc_state_t st; // Sequencer state.
        logic is_cal; // Current run is a self-calibration.
        logic cal_done; // Self-calibration has run since reset.
        logic sw_start; // Software start bit.
        logic [1:0] calslt; // Calibration select bits.
        logic [15:0] offset; // Offset trim.
        logic [15:0] gain; // Gain trim.
        logic [7:0] falls; // Master clock falls since the run began.
        logic [3:0] age; // Cycles since the start was taken.
        logic busy; // Busy output.
        logic hold; // Track and hold in hold.
        logic [15:0] dout; // Read data.
        logic doe; // Data pins driven.
    } adcc_ctrl_t;

    adcc_ctrl_t q, d;
    adcc_sar_if sar ();

    logic [23:0] pins; // Raw pin levels.
    logic [23:0] filt_d; // Filtered pin levels of the next cycle.
    logic mclk_fall; // Master clock fell.
    logic mclk_rise; // Master clock rose.
    logic pin_start; // Start pin rose.
    logic wr_end; // Write strobe ended with chip select low.
    logic [1:0] wr_addr; // Address held during the write.
    logic [15:0] wr_data; // Data held during the write.
    logic sw_req; // Write sets the software start bit.
    logic start_any; // Any start request this cycle.
    logic [7:0] run_falls; // Falls that end the current run.

    assign pins = {addr, data_in, cmp_high, wr_n, rd_n, cs_n, convert_start_n, master_clock_in};

    // Edge and request decode from the filtered pins.
    always_comb begin
        // A filtered level moves only when the last two stages agree.
        filt_d = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
        mclk_fall = q.filt[0] & ~filt_d[0];
        mclk_rise = ~q.filt[0] & filt_d[0];
        pin_start = ~q.filt[1] & filt_d[1];
        wr_end = ~q.filt[4] & filt_d[4] & ~q.filt[2];
        wr_addr = q.filt[23:22];
        wr_data = q.filt[21:6];
        sw_req = wr_end && wr_addr == REG_CTRL && wr_data[CTRL_SWSTART_BIT];
        start_any = pin_start | sw_req;
        run_falls = q.is_cal ? 8'(CAL_FALLS) : CONV_FALLS;
    end

    // Next state: synchroniser, sequencer and register port.
    always_comb begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.filt = filt_d;
        sar.start = 1'b0;
        sar.step = 1'b0;
        sar.finish = 1'b0;
        sar.cmp = q.filt[5];
        sar.offset = q.offset;
        sar.gain = q.gain;
        // Register writes land when the write strobe ends.
        if (wr_end) begin
            case (wr_addr)
                REG_CTRL: begin
                    d.sw_start = wr_data[CTRL_SWSTART_BIT];
                    d.calslt = wr_data[CTRL_CALSLT_LO +: 2];
                end
                REG_OFFSET: begin
                    d.offset = {2'b00, wr_data[TRIM_DATA_W-1:0]};
                end
                REG_GAIN: begin
                    d.gain = {2'b00, wr_data[TRIM_DATA_W-1:0]};
                end
                default: begin
                    // The status register is read only.
                end
            endcase
        end
        case (q.st)
            S_IDLE: begin
                // Only an idle sequencer takes a start.
                if (start_any) begin
                    d.busy = 1'b1;
                    d.hold = 1'b1;
                    d.is_cal = ~q.cal_done;
                    d.age = 4'h1;
                    d.st = S_ARMED;
                end
            end
            S_ARMED: begin
                if (q.age != 4'hF) begin
                    d.age = q.age + 4'h1;
                end
                // A fall too close to the start is skipped, costing one period.
                if (mclk_fall && q.age >= START_SETUP_CYC) begin
                    d.falls = 8'h00;
                    d.st = S_CONV;
                    sar.start = ~q.is_cal;
                end
            end
            S_CONV: begin
                if (mclk_fall) begin
                    d.falls = q.falls + 8'h01;
                    sar.step = ~q.is_cal && q.falls < 8'(SAR_BITS);
                    if (q.falls + 8'h01 == run_falls) begin
                        d.st = S_TAIL;
                    end
                end
            end
            S_TAIL: begin
                // The half period ends on the next master clock rise.
                if (mclk_rise) begin
                    d.busy = 1'b0;
                    d.hold = 1'b0;
                    d.st = S_IDLE;
                    d.sw_start = sw_req;
                    if (q.is_cal) begin
                        d.cal_done = 1'b1;
                        d.offset = OFFSET_CAL;
                        d.gain = GAIN_CAL;
                    end else begin
                        sar.finish = 1'b1;
                    end
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
        // Reads drive the pins while chip select and read are both low.
        d.doe = ~d.filt[2] & ~d.filt[3];
        case (d.filt[23:22])
            REG_CTRL: d.dout = {4'h0, sar.result};
            REG_STATUS: begin
                d.dout = STAT_ONES;
                d.dout[STAT_BUSY_BIT] = q.busy;
                d.dout[STAT_CALSLT_LO +: 2] = q.calslt;
                d.dout[STAT_STCAL_BIT] = q.busy & q.is_cal;
            end
            REG_OFFSET: d.dout = q.offset;
            REG_GAIN: d.dout = q.gain;
            default: d.dout = 16'h0000;
        endcase
    end

    // State register; synchroniser stages reset to the idle pin levels.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.s1 <= SYNC_RST;
            q.s2 <= SYNC_RST;
            q.s3 <= SYNC_RST;
            q.filt <= SYNC_RST;
            q.offset <= OFFSET_RST;
            q.gain <= GAIN_RST;
        end else begin
            q <= d;
        end
    end

    // Approximation core with the trims applied to its result.
    adcc_sar_core u_core (
        .clk(clk),
        .sys_rst(sys_rst),
        .sar(sar)
    );

    assign data_out = q.dout;
    assign data_oe = q.doe;
    assign busy = q.busy;
    assign hold = q.hold;
    assign dac_code = sar.dac_code;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // A start that is taken, then busy and hold raised in the armed state.
    sequence s_taken;
        q.st == S_IDLE && start_any;
    endsequence
    sequence s_held;
        q.busy && q.hold && q.st == S_ARMED;
    endsequence

    a_start_holds: assert property (s_taken |=> s_held)
        else $error("start did not raise busy and hold");
    a_first_is_cal: assert property (s_taken and !q.cal_done |=> q.is_cal)
        else $error("first start was not a calibration");
    a_busy_ignores: assert property (q.st != S_IDLE && start_any
        |=> $stable(q.is_cal) && q.st != S_ARMED || $past(q.st) == S_ARMED)
        else $error("start during busy restarted the run");
    // The first fall seen with the setup met begins the run at count zero.
    a_setup_met: assert property (q.st == S_ARMED && mclk_fall
        && q.age >= START_SETUP_CYC |=> q.st == S_CONV && q.falls == 8'h00)
        else $error("conversion did not begin on the first fall");
    a_conv_length: assert property ($fell(q.busy) && !q.is_cal
        |-> $past(q.falls) == CONV_FALLS)
        else $error("conversion length is not 16.5 periods");
    a_sw_cleared: assert property ($fell(q.busy) |-> !q.sw_start || $past(sw_req))
        else $error("busy fall left software start set");
    a_track_again: assert property ($fell(q.busy) |-> !q.hold ##1 q.st == S_IDLE)
        else $error("hold did not end with busy");
    a_trim_top_zero: assert property (q.offset[15:14] == 2'b00
        && q.gain[15:14] == 2'b00)
        else $error("trim top bits not zero");
    a_read_drives: assert property (!d.filt[2] && !d.filt[3] |=> q.doe)
        else $error("read did not drive data pins");
    a_status_busy: assert property (q.doe && q.filt[23:22] == REG_STATUS
        |=> q.dout[STAT_BUSY_BIT] == $past(q.busy))
        else $error("status busy bit wrong");
endmodule

// [shared/adcc_pkg.sv]
// Shared constants and types of the converter control block.
package adcc_pkg;
    localparam int CLK_PERIOD_NS = 100; // System clock period, 10 MHz.
    localparam int START_SETUP_NS = 10; // Start edge setup before the master clock fall.
    localparam int START_SETUP_RAW = (START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] START_SETUP_CYC = 4'((START_SETUP_RAW < 1) ? 1 : START_SETUP_RAW);
    localparam int CONV_HALF_PERIODS = 33; // A conversion lasts 16.5 master periods.
    localparam logic [7:0] CONV_FALLS = 8'(CONV_HALF_PERIODS / 2);
    localparam int SAR_BITS = 12; // Result width.
    localparam int SYNC_W = 24; // Pins passed through the input synchroniser.
    localparam logic [23:0] SYNC_RST = 24'h00_001E; // Active-low pins idle high.
    // Register addresses on the parallel port.
    localparam logic [1:0] REG_CTRL = 2'h0; // Read: result. Write: control.
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_OFFSET = 2'h2;
    localparam logic [1:0] REG_GAIN = 2'h3;
    // Control and status fields.
    localparam int CTRL_SWSTART_BIT = 0;
    localparam int CTRL_CALSLT_LO = 1;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_CALSLT_LO = 1;
    localparam int STAT_STCAL_BIT = 0;
    localparam logic [15:0] STAT_ONES = 16'h00C0;
    // Trim registers: two zero bits above fourteen data bits.
    localparam int TRIM_DATA_W = 14;
    localparam logic [13:0] TRIM_CENTER = 14'h2000;
    localparam logic [15:0] OFFSET_RST = 16'h2000;
    localparam logic [15:0] GAIN_RST = 16'h2000;
    // Offset step is 1/40 result LSB, gain step is 1/327680 of the result.
    localparam logic signed [47:0] OFF_SCALE = 48'sh0000_0000_3333;
    localparam int OFF_SHIFT = 19;
    localparam logic signed [47:0] GAIN_SCALE = 48'sh0000_0000_3333;
    localparam int GAIN_SHIFT = 32;
    localparam logic [11:0] SAR_FIRST = 12'h800;
    typedef enum logic [1:0] {S_IDLE, S_ARMED, S_CONV, S_TAIL} adcc_state_t;
endpackage

// [shared/adcc_sar_if.sv]
// Link between the conversion sequencer and the approximation core.
`timescale 1ns/1ps
interface adcc_sar_if;
    logic start; // Begin a new approximation.
    logic step; // Decide one bit.
    logic finish; // Correct and latch the result.
    logic cmp; // Synchronised comparator level.
    logic [15:0] offset; // Offset trim.
    logic [15:0] gain; // Gain trim.
    logic [11:0] dac_code; // Trial code.
    logic [11:0] result; // Corrected result.
    modport ctrl (output start, step, finish, cmp, offset, gain, input dac_code, result);
    modport core (input start, step, finish, cmp, offset, gain, output dac_code, result);
endinterface

// [rtl/adcc_sar_core.sv]
// Successive approximation register with offset and gain correction.
`timescale 1ns/1ps
module adcc_sar_core (
    input wire logic clk,
    input wire logic sys_rst,
    adcc_sar_if.core sar
);
    import adcc_pkg::*;

    // All state of the core.
    typedef struct packed {
        logic [11:0] code;
        logic [3:0] idx;
        logic [11:0] result;
    } adcc_core_t;

    adcc_core_t q, d;

    // Applies offset and gain trims to a raw code and clamps it to range.
    function automatic logic [11:0] adcc_correct(input logic [11:0] raw,
                                                 input logic [15:0] off,
                                                 input logic [15:0] gn);
        logic signed [47:0] od;
        logic signed [47:0] gd;
        logic signed [47:0] rw;
        logic signed [47:0] sum;
        od = 48'($signed({1'b0, off[13:0]})) - 48'($signed({1'b0, TRIM_CENTER}));
        gd = 48'($signed({1'b0, gn[13:0]})) - 48'($signed({1'b0, TRIM_CENTER}));
        rw = 48'($signed({1'b0, raw}));
        // A larger offset adds, a larger gain stretches the result.
        // Half a result LSB is added before each shift, so each correction rounds to the nearest LSB.
        sum = rw + ((od * OFF_SCALE + 48'sh0000_0004_0000) >>> OFF_SHIFT)
            + ((rw * gd * GAIN_SCALE + 48'sh0000_8000_0000) >>> GAIN_SHIFT);
        if (sum < 0) begin
            adcc_correct = 12'h000;
        end else if (sum > 48'sh0000_0000_0FFF) begin
            adcc_correct = 12'hFFF;
        end else begin
            adcc_correct = sum[11:0];
        end
    endfunction

    // Next state: trial bits from the top down, correction at the end.
    always_comb begin
        d = q;
        if (sar.start) begin
            d.code = SAR_FIRST;
            d.idx = 4'(SAR_BITS - 1);
        end else if (sar.step) begin
            // Keep the trial bit while the input stays above the trial level.
            d.code[q.idx] = sar.cmp;
            if (q.idx != 4'h0) begin
                d.code[q.idx - 4'h1] = 1'b1;
                d.idx = q.idx - 4'h1;
            end
        end
        if (sar.finish) begin
            d.result = adcc_correct(q.code, sar.offset, sar.gain);
        end
    end

    // State register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sar.dac_code = q.code;
    assign sar.result = q.result;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_start_first_trial: assert property (sar.start
        |=> q.code == SAR_FIRST && q.idx == 4'hB)
        else $error("trial code not preset");
    a_centre_trim_pass: assert property (sar.finish
        && sar.offset[13:0] == TRIM_CENTER
        && sar.gain[13:0] == TRIM_CENTER |=> q.result == $past(q.code))
        else $error("centred trims changed the result");
    a_offset_raises: assert property (sar.finish && q.code < 12'hF00
        && sar.gain[13:0] == TRIM_CENTER && sar.offset[13:0] >= 14'h2028
        |=> q.result > $past(q.code))
        else $error("positive offset trim did not raise result");
endmodule

// [test/adcc_afe_model.sv]
// Behavioural model of the analog side: master clock source and comparator.
`timescale 1ns/1ps
module adcc_afe_model #(
    parameter int HALF_NS = 400 // Master clock half period in nanoseconds.
) (
    input wire logic [11:0] vin_code, // Sampled input expressed as a result code.
    input wire logic [11:0] dac_code, // Trial code from the converter.
    output logic master_clock_in, // Free running master clock.
    output logic cmp_high // Comparator decision.
);
    // The master clock runs free, with a phase unrelated to the system clock.
    initial begin
        master_clock_in = 1'b1;
        #37;
        forever #(HALF_NS) master_clock_in = ~master_clock_in;
    end
    // The input sits half a step above its code, so a trial equal to it keeps its bit.
    assign cmp_high = (vin_code >= dac_code);
endmodule

// [test/tb_top.sv]
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
module tb_top;
    import adcc_pkg::*;
    localparam int MP = 8; // System clocks in one master clock period.
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic convert_start_n = 1'b1;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [15:0] data_in = 16'h0000;
    logic [11:0] vin_code = 12'h000;
    logic master_clock_in;
    logic cmp_high;
    logic [15:0] data_out;
    logic data_oe;
    logic busy;
    logic hold;
    logic [11:0] dac_code;
    int error_cnt = 0;
    int compares = 0;
    int len;
    int w;
    logic [15:0] rd_val;
    logic [15:0] st_val;
    // Trim settings, input codes and corrected results of the trim scenarios.
    logic [15:0] trim_off [3] = '{16'h2190, 16'h1E70, 16'h2000};
    logic [15:0] trim_gn [3] = '{16'h2000, 16'h2000, 16'h3000};
    logic [11:0] trim_vin [3] = '{12'h5A3, 12'h5A3, 12'hA00};
    logic [15:0] trim_exp [3] = '{16'h05AD, 16'h0599, 16'h0A20};

    // The system clock runs at 10 MHz.
    always #50 clk = ~clk;

    adcc_ctrl #(.CAL_FALLS(16)) adcc_ctrl_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .master_clock_in(master_clock_in),
        .convert_start_n(convert_start_n),
        .cs_n(cs_n),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .addr(addr),
        .data_in(data_in),
        .cmp_high(cmp_high),
        .data_out(data_out),
        .data_oe(data_oe),
        .busy(busy),
        .hold(hold),
        .dac_code(dac_code)
    );

    adcc_afe_model adcc_afe_model_inst (
        .vin_code(vin_code),
        .dac_code(dac_code),
        .master_clock_in(master_clock_in),
        .cmp_high(cmp_high)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A wait that ran out of its bound counts as a mismatch and ends the run.
    task automatic timeout();
        error_cnt++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
        wrap_up();
    endtask

    // Lets a number of falling clock edges pass.
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Reads one word; the strobes stay low until the pins are driven.
    task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        for (n = 0; n < 20 && data_oe !== 1'b1; n++) @(negedge clk);
        if (n == 20) timeout();
        @(negedge clk);
        d = data_out;
        cs_n = 1'b1;
        rd_n = 1'b1;
        idle(6);
    endtask

    // Writes one word; address and data stay put well past the strobe rise.
    task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        data_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        idle(6);
        wr_n = 1'b1;
        idle(6);
        cs_n = 1'b1;
        idle(6);
    endtask

    // Starts a run by pin or by control write and measures how long busy stands.
    task automatic run_conv(input logic [11:0] v, input bit sw, input bit poke,
                            input bit peek);
        int n;
        vin_code = v;
        if (sw) begin
            bus_wr(REG_CTRL, 16'h0001);
        end else begin
            @(negedge clk);
            convert_start_n = 1'b0;
            idle(6);
            convert_start_n = 1'b1;
        end
        for (n = 0; n < 30 && busy !== 1'b1; n++) @(negedge clk);
        if (n == 30) timeout();
        chk({15'h0000, hold}, 16'h0001);
        if (peek) begin
            bus_rd(REG_STATUS, st_val);
        end
        // A second start pulse in mid-run must leave the run alone.
        for (len = 0; len < 400 && busy === 1'b1; len++) begin
            @(negedge clk);
            convert_start_n = (poke && len >= 20 && len < 26) ? 1'b0 : 1'b1;
        end
        if (len == 400) timeout();
        chk({15'h0000, hold}, 16'h0000);
        idle(6);
    endtask

    // Main sequence.
    initial begin
        idle(20);
        sys_rst = 1'b0;
        idle(2);
        bus_rd(REG_STATUS, rd_val);
        chk(rd_val, STAT_ONES);
        chk({15'h0000, data_oe}, 16'h0000);
        bus_rd(REG_OFFSET, rd_val);
        chk(rd_val, OFFSET_RST);
        bus_rd(REG_GAIN, rd_val);
        chk(rd_val, GAIN_RST);
        // The first start calibrates, and status shows busy and calibration.
        // Results are relied on only once the calibration has ended.
        run_conv(12'h5A3, 1'b0, 1'b0, 1'b1);
        chk(st_val, STAT_ONES | 16'h0011);
        // A pin start converts in 16.5 or 17.5 master periods.
        run_conv(12'h5A3, 1'b0, 1'b0, 1'b0);
        chk(16'(len >= 16 * MP && len <= 18 * MP + 4), 16'h0001);
        bus_rd(REG_CTRL, rd_val);
        chk(rd_val, 16'h05A3);
        chk({4'h0, dac_code}, 16'h05A3);
        // Two software starts back to back: the bit must clear in between.
        run_conv(12'hA5C, 1'b1, 1'b0, 1'b0);
        bus_rd(REG_CTRL, rd_val);
        chk(rd_val, 16'h0A5C);
        run_conv(12'h3C3, 1'b1, 1'b0, 1'b0);
        bus_rd(REG_CTRL, rd_val);
        chk(rd_val, 16'h03C3);
        // A start pulse during busy neither stretches nor repeats the run.
        run_conv(12'h7E1, 1'b0, 1'b1, 1'b0);
        chk(16'(len >= 16 * MP && len <= 18 * MP + 4), 16'h0001);
        idle(40);
        chk({15'h0000, busy}, 16'h0000);
        bus_rd(REG_CTRL, rd_val);
        chk(rd_val, 16'h07E1);
        // At full rate the control write stands past the busy fall, then starts a run.
        vin_code = 12'h2B4;
        convert_start_n = 1'b0;
        idle(6);
        convert_start_n = 1'b1;
        idle(40);
        addr = REG_CTRL;
        data_in = 16'h0001;
        cs_n = 1'b0;
        wr_n = 1'b0;
        for (w = 0; w < 400 && busy === 1'b1; w++) @(negedge clk);
        if (w == 400) timeout();
        vin_code = 12'h4C7;
        idle(6);
        wr_n = 1'b1;
        idle(6);
        cs_n = 1'b1;
        chk({15'h0000, busy}, 16'h0001);
        for (w = 0; w < 400 && busy === 1'b1; w++) @(negedge clk);
        if (w == 400) timeout();
        idle(6);
        bus_rd(REG_CTRL, rd_val);
        chk(rd_val, 16'h04C7);
        // Trim registers keep their top two bits at zero; status ignores writes.
        bus_wr(REG_OFFSET, 16'hFFFF);
        bus_rd(REG_OFFSET, rd_val);
        chk(rd_val, 16'h3FFF);
        bus_wr(REG_GAIN, 16'hC000);
        bus_rd(REG_GAIN, rd_val);
        chk(rd_val, 16'h0000);
        bus_wr(REG_STATUS, 16'hFFFF);
        bus_rd(REG_STATUS, rd_val);
        chk(rd_val, STAT_ONES);
        // Offset up and down, then gain up, each with an exact correction.
        for (int i = 0; i < 3; i++) begin
            bus_wr(REG_OFFSET, trim_off[i]);
            bus_wr(REG_GAIN, trim_gn[i]);
            run_conv(trim_vin[i], 1'b0, 1'b0, 1'b0);
            bus_rd(REG_CTRL, rd_val);
            chk(rd_val, trim_exp[i]);
        end
        wrap_up();
    end
endmodule
